/* File: common/nptc_pkg.sv */
// Shared constants and types of the nibble/PCM port test control block
package nptc_pkg;
    // Clock and timing
    localparam int NPTC_PCLK_NS = 5;
    localparam int NPTC_LB_SETTLE_NS = 50;
    localparam int NPTC_LB_SETTLE_CYC = (NPTC_LB_SETTLE_NS + NPTC_PCLK_NS - 1) / NPTC_PCLK_NS;
    localparam int NPTC_OFF_W = 16;
    localparam int NPTC_PCM_W = 16;

    // Register byte offsets
    localparam logic [7:0] NPTC_CTRL_OFF = 8'h00;
    localparam logic [7:0] NPTC_FORCE_OFF = 8'h04;
    localparam logic [7:0] NPTC_NOFF_OFF = 8'h08;
    localparam logic [7:0] NPTC_TOFF_OFF = 8'h0c;
    localparam logic [7:0] NPTC_LBCMD_OFF = 8'h10;
    localparam logic [7:0] NPTC_LBSTAT_OFF = 8'h14;
    localparam logic [7:0] NPTC_ISTAT_OFF = 8'h18;
    localparam logic [7:0] NPTC_IMASK_OFF = 8'h1c;

    // Field positions
    localparam int NPTC_FORCE_VAL_LSB = 4;
    localparam int NPTC_LB_BUSY_BIT = 0;
    localparam int NPTC_LB_PASS_LSB = 4;
    localparam int NPTC_LB_FAIL_LSB = 8;
    localparam int NPTC_EV_PULSE = 0;
    localparam int NPTC_EV_LB_DONE = 1;
    localparam int NPTC_EV_LB_FAIL = 2;
    localparam int NPTC_EV_W = 3;

    // Loopback walk patterns and checked pairs (lines 0, 2, 3)
    localparam logic [3:0] NPTC_LB_PAT [4] = '{4'h0, 4'hf, 4'h5, 4'ha};
    localparam logic [3:0] NPTC_LB_PAIRS = 4'hd;

    // Control register, bit 7 first from the top
    typedef struct packed {
        logic master_clk;
        logic test_mode;
        logic truncated;
        logic pcm_tx_count_pattern_on;
        logic nibble_tx_pattern_on;
        logic third_serial_port;
        logic long_compressed_format;
        logic vocoder_conformance_mode;
    } nptc_ctrl_t;

    // Vocoder control nibble
    typedef struct packed {
        logic error_clear;
        logic lost;
        logic mute;
        logic init;
    } nptc_cnib_t;

    typedef enum logic {NPTC_LB_IDLE, NPTC_LB_RUN} nptc_lb_state_t;

    typedef struct packed {
        nptc_lb_state_t st;
        logic [1:0] step;
        logic [7:0] cnt;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] enc;
        logic [3:0] pass;
        logic [3:0] fail;
        logic done;
    } nptc_lb_st_t;

    typedef struct packed {
        logic [NPTC_OFF_W-1:0] cnt;
        logic armed;
        logic pulse;
        logic fired;
    } nptc_fo_st_t;

    typedef struct packed {
        nptc_ctrl_t ctrl;
        logic [3:0] fen;
        logic [3:0] fval;
        logic [NPTC_OFF_W-1:0] noff;
        logic [NPTC_OFF_W-1:0] toff;
        logic [NPTC_EV_W-1:0] ist;
        logic [NPTC_EV_W-1:0] imask;
        logic [31:0] prdata;
        logic ack;
        logic err;
        logic nclk_s1;
        logic nclk_s2;
        logic nclk_d;
        logic fm_s1;
        logic fm_s2;
        logic fm_d;
        logic [3:0] nib_cnt;
        logic [NPTC_PCM_W-1:0] pcm_cnt;
        logic [3:0] enc;
        logic [3:0] cnib;
        logic [NPTC_PCM_W-1:0] pcm;
        logic [NPTC_PCM_W-1:0] ana;
        logic ana_v;
        logic lb_start;
    } nptc_main_st_t;

    localparam nptc_main_st_t NPTC_MAIN_RST = '0;
    localparam nptc_lb_st_t NPTC_LB_RST = '0;
    localparam nptc_fo_st_t NPTC_FO_RST = '0;
endpackage

/* File: verilog/nptc_frame_offset.sv */
// Second frame pulse placement after the first frame pulse
module nptc_frame_offset
    import nptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic nclk_rise,
    input wire logic first_frame_pulse_rise,
    input wire logic [NPTC_OFF_W-1:0] offset,
    output logic pulse,
    output logic fired
);
    nptc_fo_st_t r;
    nptc_fo_st_t n;

    // Count nibble clock edges from the first pulse, fire at the offset
    always_comb begin
        n = r;
        n.fired = 1'b0;
        if (!enable) begin
            n.armed = 1'b0;
            n.pulse = 1'b0;
        end else if (first_frame_pulse_rise) begin
            n.cnt = '0;
            n.pulse = (offset == '0);
            n.fired = (offset == '0);
            n.armed = (offset != '0);
        end else if (nclk_rise) begin
            // One nibble clock period wide, ended by the next edge
            n.pulse = 1'b0;
            if (r.armed) begin
                n.cnt = r.cnt + 1'b1;
                if (r.cnt + 1'b1 == offset) begin
                    n.pulse = 1'b1;
                    n.fired = 1'b1;
                    n.armed = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= NPTC_FO_RST;
        end else begin
            r <= n;
        end
    end

    assign pulse = r.pulse;
    assign fired = r.fired;
endmodule

/* File: verilog/nptc_loopback.sv */
// Encoder/decoder line loopback check through an external adapter
module nptc_loopback
    import nptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [3:0] decoder_line,
    output logic [3:0] enc,
    output logic active,
    output logic done,
    output logic [3:0] pass,
    output logic [3:0] fail
);
    nptc_lb_st_t r;
    nptc_lb_st_t n;
    logic [3:0] miss;

    // Mismatches on checked pairs only; the adapter closes each pair
    assign miss = (r.s2 ^ r.enc) & NPTC_LB_PAIRS;

    always_comb begin
        n = r;
        n.s1 = decoder_line;
        n.s2 = r.s1;
        n.done = 1'b0;
        unique case (r.st)
            NPTC_LB_IDLE: begin
                if (start) begin
                    n.st = NPTC_LB_RUN;
                    n.step = 2'd0;
                    n.cnt = '0;
                    n.enc = NPTC_LB_PAT[0];
                    n.fail = '0;
                    n.pass = '0;
                end
            end
            NPTC_LB_RUN: begin
                // Wait covers the wiring plus the two sync stages
                n.cnt = r.cnt + 1'b1;
                if (r.cnt == 8'(NPTC_LB_SETTLE_CYC + 2)) begin
                    n.cnt = '0;
                    n.fail = r.fail | miss;
                    if (r.step == 2'd3) begin
                        n.pass = ~(r.fail | miss) & NPTC_LB_PAIRS;
                        n.done = 1'b1;
                        n.st = NPTC_LB_IDLE;
                        n.enc = '0;
                    end else begin
                        n.step = r.step + 1'b1;
                        n.enc = NPTC_LB_PAT[r.step + 1'b1];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= NPTC_LB_RST;
        end else begin
            r <= n;
        end
    end

    assign enc = r.enc;
    assign active = (r.st == NPTC_LB_RUN);
    assign done = r.done;
    assign pass = r.pass;
    assign fail = r.fail;
endmodule

/* File: verilog/nptc_top.sv */
// Nibble/PCM port test control: patterns, forced bits, frame offset, loopback
//
// Decided for this implementation: the address map and the APB slave port.
module nptc_top
    import nptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nibble_clock,
    input wire logic first_frame_pulse,
    output logic second_frame_pulse,
    input wire logic [3:0] voc_nibble,
    input wire nptc_cnib_t voc_ctrl_nibble,
    output logic [3:0] encoder_line,
    input wire logic [3:0] decoder_line,
    output nptc_cnib_t tx_ctrl_nibble,
    input wire logic pcm_sample_en,
    input wire logic [NPTC_PCM_W-1:0] voc_pcm,
    output logic [NPTC_PCM_W-1:0] pcm_tx_data,
    input wire logic mixer_com_valid,
    input wire logic [NPTC_PCM_W-1:0] mixer_com_data,
    output logic analysis_valid,
    output logic [NPTC_PCM_W-1:0] analysis_data,
    output logic vocoder_conformance_mode,
    output logic long_compressed_format,
    output logic third_serial_port,
    output logic irq
);
    nptc_main_st_t r;
    nptc_main_st_t n;

    logic access;
    logic nclk_rise;
    logic first_frame_pulse_rise;
    logic fo_enable;
    logic [NPTC_OFF_W-1:0] fo_offset;
    logic fo_fired;
    logic lb_active;
    logic lb_done;
    logic [3:0] lb_enc;
    logic [3:0] lb_pass;
    logic [3:0] lb_fail;
    logic [NPTC_EV_W-1:0] ev;
    logic [NPTC_EV_W-1:0] iclr;

    // Address decode for the error answer; the read mux decodes the address on its own
    function automatic logic is_mapped(input logic [7:0] a);
        unique case (a)
            NPTC_CTRL_OFF, NPTC_FORCE_OFF, NPTC_NOFF_OFF, NPTC_TOFF_OFF,
            NPTC_LBCMD_OFF, NPTC_LBSTAT_OFF, NPTC_ISTAT_OFF,
            NPTC_IMASK_OFF: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Read mux; unused upper bits read as zero
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input nptc_main_st_t s,
                                            input logic busy,
                                            input logic [3:0] pass,
                                            input logic [3:0] fail);
        logic [31:0] w;
        w = '0;
        unique case (a)
            NPTC_CTRL_OFF: w[7:0] = s.ctrl;
            NPTC_FORCE_OFF: w[7:0] = {s.fval, s.fen};
            NPTC_NOFF_OFF: w[NPTC_OFF_W-1:0] = s.noff;
            NPTC_TOFF_OFF: w[NPTC_OFF_W-1:0] = s.toff;
            NPTC_LBSTAT_OFF: begin
                w[NPTC_LB_BUSY_BIT] = busy;
                w[NPTC_LB_PASS_LSB +: 4] = pass;
                w[NPTC_LB_FAIL_LSB +: 4] = fail;
            end
            NPTC_ISTAT_OFF: w[NPTC_EV_W-1:0] = s.ist;
            NPTC_IMASK_OFF: w[NPTC_EV_W-1:0] = s.imask;
            default: w = '0;
        endcase
        return w;
    endfunction

    // Edges of the synchronised link signals, read from second stage on
    assign nclk_rise = r.nclk_s2 & ~r.nclk_d;
    assign first_frame_pulse_rise = r.fm_s2 & ~r.fm_d;

    // Second pulse only as clock master in test mode
    assign fo_enable = r.ctrl.master_clk & r.ctrl.test_mode;
    // Truncated bit selects which offset is in force
    assign fo_offset = r.ctrl.truncated ? r.toff : r.noff;

    nptc_frame_offset u_frame_offset (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fo_enable),
        .nclk_rise(nclk_rise),
        .first_frame_pulse_rise(first_frame_pulse_rise),
        .offset(fo_offset),
        .pulse(second_frame_pulse),
        .fired(fo_fired)
    );

    nptc_loopback u_loopback (
        .pclk(pclk),
        .presetn(presetn),
        .start(r.lb_start),
        .decoder_line(decoder_line),
        .enc(lb_enc),
        .active(lb_active),
        .done(lb_done),
        .pass(lb_pass),
        .fail(lb_fail)
    );

    // APB access phase; one wait state while read data is latched
    assign access = psel & penable;
    assign pready = access & r.ack;
    assign pslverr = pready & r.err;

    // Events that set sticky status bits
    always_comb begin
        ev = '0;
        ev[NPTC_EV_PULSE] = fo_fired;
        ev[NPTC_EV_LB_DONE] = lb_done;
        ev[NPTC_EV_LB_FAIL] = lb_done & (lb_fail != 4'h0);
    end

    // Write-one-to-clear mask, only at the completing edge
    always_comb begin
        iclr = '0;
        if (pready && pwrite && !r.err && paddr == NPTC_ISTAT_OFF) begin
            iclr = pwdata[NPTC_EV_W-1:0];
        end
    end

    // Next state of everything the top module holds
    always_comb begin
        n = r;
        n.lb_start = 1'b0;

        // Two-stage synchronisers for the link pins
        n.nclk_s1 = nibble_clock;
        n.nclk_s2 = r.nclk_s1;
        n.nclk_d = r.nclk_s2;
        n.fm_s1 = first_frame_pulse;
        n.fm_s2 = r.fm_s1;
        n.fm_d = r.fm_s2;

        // Register access
        if (access && !r.ack) begin
            n.ack = 1'b1;
            n.err = ~is_mapped(paddr);
            n.prdata = rd_word(paddr, r, lb_active, lb_pass, lb_fail);
        end
        if (pready) begin
            n.ack = 1'b0;
            if (pwrite && !r.err) begin
                unique case (paddr)
                    // Settings are plain on/off bits
                    NPTC_CTRL_OFF: n.ctrl = nptc_ctrl_t'(pwdata[7:0]);
                    NPTC_FORCE_OFF: begin
                        n.fen = pwdata[3:0];
                        n.fval = pwdata[NPTC_FORCE_VAL_LSB +: 4];
                    end
                    NPTC_NOFF_OFF: n.noff = pwdata[NPTC_OFF_W-1:0];
                    NPTC_TOFF_OFF: n.toff = pwdata[NPTC_OFF_W-1:0];
                    // Start is ignored while a walk is already running
                    NPTC_LBCMD_OFF: n.lb_start = pwdata[0] & ~lb_active;
                    NPTC_IMASK_OFF: n.imask = pwdata[NPTC_EV_W-1:0];
                    default: n.lb_start = 1'b0;
                endcase
            end
        end

        // Sticky status: a set in the clearing cycle wins
        n.ist = (r.ist & ~iclr) | ev;

        // Nibble transmit: loopback walk, test count, or vocoder data
        if (lb_active) begin
            n.enc = lb_enc;
        end else if (nclk_rise) begin
            n.nib_cnt = r.nib_cnt + 1'b1;
            n.enc = r.ctrl.nibble_tx_pattern_on ? r.nib_cnt : voc_nibble;
        end

        // Forced bits replace vocoder bits only where enabled
        n.cnib = (voc_ctrl_nibble & ~r.fen) | (r.fval & r.fen);

        // PCM transmit; count restarts from zero each time it is enabled
        if (!r.ctrl.pcm_tx_count_pattern_on) begin
            n.pcm_cnt = '0;
        end
        if (pcm_sample_en) begin
            if (r.ctrl.pcm_tx_count_pattern_on) begin
                n.pcm = r.pcm_cnt;
                n.pcm_cnt = r.pcm_cnt + 1'b1;
            end else begin
                n.pcm = voc_pcm;
            end
        end

        // Analysis sees the mixer COM port and nothing else
        n.ana_v = mixer_com_valid;
        if (mixer_com_valid) begin
            n.ana = mixer_com_data;
        end
    end

    // All settings come up off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= NPTC_MAIN_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from state
    assign prdata = r.prdata;
    assign encoder_line = r.enc;
    assign tx_ctrl_nibble = nptc_cnib_t'(r.cnib);
    assign pcm_tx_data = r.pcm;
    assign analysis_valid = r.ana_v;
    assign analysis_data = r.ana;
    assign vocoder_conformance_mode = r.ctrl.vocoder_conformance_mode;
    assign long_compressed_format = r.ctrl.long_compressed_format;
    assign third_serial_port = r.ctrl.third_serial_port;
    // Level interrupt while any unmasked status bit stands
    assign irq = |(r.ist & r.imask);
endmodule

/* File: testbench/nptc_props.sv */
// Port checker for the nibble/PCM port test control block
module nptc_props
    import nptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic second_frame_pulse,
    input wire nptc_cnib_t voc_ctrl_nibble,
    input wire nptc_cnib_t tx_ctrl_nibble,
    input wire logic pcm_sample_en,
    input wire logic [NPTC_PCM_W-1:0] voc_pcm,
    input wire logic [NPTC_PCM_W-1:0] pcm_tx_data,
    input wire logic mixer_com_valid,
    input wire logic [NPTC_PCM_W-1:0] mixer_com_data,
    input wire logic analysis_valid,
    input wire logic [NPTC_PCM_W-1:0] analysis_data,
    input wire logic vocoder_conformance_mode,
    input wire logic long_compressed_format,
    input wire logic third_serial_port
);
    logic [7:0] ctrl_r;
    logic [3:0] fen_r;
    logic [3:0] fval_r;
    logic wr_ok;
    // Shadow control and force registers, loaded at the APB write edge
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 8'h00;
            {fval_r, fen_r} <= 8'h00;
        end else if (wr_ok && paddr == NPTC_CTRL_OFF) begin
            ctrl_r <= pwdata[7:0];
        end else if (wr_ok && paddr == NPTC_FORCE_OFF) begin
            {fval_r, fen_r} <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // Pulse gating needs master clock or test mode off for two cycles running
    sequence s_gate_off;
        !(ctrl_r[7] && ctrl_r[6]);
    endsequence
    property p_one_wait;
        s_setup ##1 (psel && penable) |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready wait wrong");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_setting;
        {third_serial_port, long_compressed_format, vocoder_conformance_mode} == ctrl_r[2:0];
    endproperty
    a_setting: assert property (p_setting) else $error("setting output wrong");
    property p_force;
        $past(presetn) |-> tx_ctrl_nibble == (($past(fen_r) & $past(fval_r))
            | (~$past(fen_r) & $past(voc_ctrl_nibble)));
    endproperty
    a_force: assert property (p_force) else $error("control nibble wrong");
    property p_pcm_thru;
        pcm_sample_en && !ctrl_r[4] |=> pcm_tx_data == $past(voc_pcm);
    endproperty
    a_pcm_thru: assert property (p_pcm_thru) else $error("pcm pass-through wrong");
    property p_analysis;
        mixer_com_valid |=> analysis_valid && analysis_data == $past(mixer_com_data);
    endproperty
    a_analysis: assert property (p_analysis) else $error("analysis copy wrong");
    property p_pulse_width;
        $rose(second_frame_pulse) |-> second_frame_pulse [*8];
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");
    property p_pulse_ends;
        $rose(second_frame_pulse) |-> ##[8:40] !second_frame_pulse;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse too long");
    property p_pulse_gated;
        s_gate_off ##1 s_gate_off |-> !second_frame_pulse;
    endproperty
    a_pulse_gated: assert property (p_pulse_gated) else $error("pulse outside test");
endmodule

bind nptc_top nptc_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .second_frame_pulse(second_frame_pulse), .voc_ctrl_nibble(voc_ctrl_nibble),
    .tx_ctrl_nibble(tx_ctrl_nibble), .pcm_sample_en(pcm_sample_en), .voc_pcm(voc_pcm),
    .pcm_tx_data(pcm_tx_data), .mixer_com_valid(mixer_com_valid),
    .mixer_com_data(mixer_com_data), .analysis_valid(analysis_valid),
    .analysis_data(analysis_data), .vocoder_conformance_mode(vocoder_conformance_mode),
    .long_compressed_format(long_compressed_format), .third_serial_port(third_serial_port)
);

/* File: testbench/nptc_host_model.sv */
// Host-side model: nibble link clock, frame pulse and loopback adapter
module nptc_host_model (
    input wire logic frame_go,
    input wire logic break_line,
    input wire logic [3:0] encoder_line,
    output logic nibble_clock,
    output logic first_frame_pulse,
    output logic [3:0] decoder_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF_NS = 80;
    localparam int FRAME_CLKS = 8;
    // Adapter loops each line back; a broken line 2 reads inverted
    assign decoder_line = break_line ? (encoder_line ^ 4'h4) : encoder_line;
    initial begin
        nibble_clock = 1'b0;
        first_frame_pulse = 1'b0;
    end
    // One frame per request; link clock stands low between frames
    always @(posedge frame_go) begin
        // Start off the bench clock edges so the pins never race a sample
        #1;
        first_frame_pulse = 1'b1;
        repeat (FRAME_CLKS) begin
            #(HALF_NS) nibble_clock = 1'b1;
            first_frame_pulse = 1'b0;
            #(HALF_NS) nibble_clock = 1'b0;
        end
    end
endmodule

/* File: testbench/test_nptc_top.sv */
// Self-checking bench for the nibble/PCM port test control block
module test_nptc_top
    import nptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic nibble_clock, first_frame_pulse, second_frame_pulse, frame_go, break_line, e;
    logic [3:0] voc_nibble, encoder_line, decoder_line, e2, e3;
    nptc_cnib_t voc_ctrl_nibble, tx_ctrl_nibble;
    logic pcm_sample_en, mixer_com_valid, analysis_valid, irq;
    logic [NPTC_PCM_W-1:0] voc_pcm, pcm_tx_data, mixer_com_data, analysis_data;
    logic vocoder_conformance_mode, long_compressed_format, third_serial_port;
    int n_mismatch = 0;
    int n_tests = 0;
    localparam logic [7:0] RST_OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c};
    localparam logic [7:0] FRC [4] = '{8'haf, 8'h03, 8'h88, 8'h00};
    localparam logic [3:0] FRC_EXP [4] = '{4'ha, 4'h4, 4'hd, 4'h5};
    localparam logic [7:0] FR_CTRL [4] = '{8'h40, 8'hc8, 8'he0, 8'hc0};
    localparam int FR_NOFF [4] = '{5, 5, 5, 0};
    localparam int FR_EXP [4] = '{8, 5, 3, 0};

    nptc_top DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nibble_clock(nibble_clock), .first_frame_pulse(first_frame_pulse),
        .second_frame_pulse(second_frame_pulse), .voc_nibble(voc_nibble),
        .voc_ctrl_nibble(voc_ctrl_nibble), .encoder_line(encoder_line),
        .decoder_line(decoder_line), .tx_ctrl_nibble(tx_ctrl_nibble),
        .pcm_sample_en(pcm_sample_en), .voc_pcm(voc_pcm), .pcm_tx_data(pcm_tx_data),
        .mixer_com_valid(mixer_com_valid), .mixer_com_data(mixer_com_data),
        .analysis_valid(analysis_valid), .analysis_data(analysis_data),
        .vocoder_conformance_mode(vocoder_conformance_mode),
        .long_compressed_format(long_compressed_format),
        .third_serial_port(third_serial_port), .irq(irq)
    );
    nptc_host_model u_host (
        .frame_go(frame_go), .break_line(break_line), .encoder_line(encoder_line),
        .nibble_clock(nibble_clock), .first_frame_pulse(first_frame_pulse),
        .decoder_line(decoder_line)
    );

    // 200 MHz bench clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One APB transfer; pready, read data and error all taken at one rising edge
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        // Release only after the completing edge, then leave one idle cycle
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask

    // Counts link clock rises seen before the second frame pulse
    task automatic frame_chk(input int exp);
        int i;
        int n;
        logic prev;
        n = 0;
        prev = 1'b0;
        frame_go <= 1'b1;
        for (i = 0; i < 300; i++) begin
            @(negedge pclk);
            if (second_frame_pulse === 1'b1) break;
            if (nibble_clock === 1'b1 && prev === 1'b0) begin
                n++;
                if (n == 2) e2 = encoder_line;
                if (n == 3) e3 = encoder_line;
            end
            prev = nibble_clock;
        end
        chk(n, exp, "frame offset");
        @(posedge pclk);
        frame_go <= 1'b0;
        repeat (300) @(posedge pclk);
    endtask

    // Main sequence
    initial begin
        int k;
        int i;
        {presetn, psel, penable, pwrite, frame_go, break_line} = '0;
        {paddr, pwdata, voc_nibble, voc_ctrl_nibble, voc_pcm, mixer_com_data} = '0;
        {pcm_sample_en, mixer_com_valid} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 7; k++) rd(RST_OFFS[k], 32'h0, "reset value");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        wr_ctrl: apb(1'b1, NPTC_CTRL_OFF, 32'h07);
        rd(NPTC_CTRL_OFF, 32'h07, "settings readback");
        voc_ctrl_nibble <= 4'h5;
        for (k = 0; k < 4; k++) begin
            apb(1'b1, NPTC_FORCE_OFF, {24'h0, FRC[k]});
            @(negedge pclk);
            chk(tx_ctrl_nibble, FRC_EXP[k], "forced nibble");
            @(posedge pclk);
        end
        // PCM counting pattern, then pass-through once switched off
        voc_pcm <= 16'h1234;
        apb(1'b1, NPTC_CTRL_OFF, 32'h10);
        for (k = 0; k < 4; k++) begin
            if (k == 3) apb(1'b1, NPTC_CTRL_OFF, 32'h00);
            pcm_sample_en <= 1'b1;
            @(posedge pclk);
            pcm_sample_en <= 1'b0;
            @(negedge pclk);
            chk(pcm_tx_data, (k == 3) ? 32'h1234 : 32'(k), "pcm pattern");
            @(posedge pclk);
        end
        mixer_com_data <= 16'h7fff;
        mixer_com_valid <= 1'b1;
        @(posedge pclk);
        mixer_com_valid <= 1'b0;
        @(negedge pclk);
        chk({analysis_valid, analysis_data}, 32'h17fff, "analysis copy");
        @(posedge pclk);
        apb(1'b1, NPTC_TOFF_OFF, 32'h3);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, NPTC_NOFF_OFF, FR_NOFF[k]);
            apb(1'b1, NPTC_CTRL_OFF, {24'h0, FR_CTRL[k]});
            frame_chk(FR_EXP[k]);
            if (k == 1) chk(e3, 4'(e2 + 4'h1), "nibble pattern");
        end
        // Event status, mask and write-one-to-clear
        rd(NPTC_ISTAT_OFF, 32'h1, "pulse event");
        chk(irq, 32'h0, "masked irq");
        apb(1'b1, NPTC_IMASK_OFF, 32'h1);
        chk(irq, 32'h1, "unmasked irq");
        apb(1'b1, NPTC_ISTAT_OFF, 32'h1);
        chk(irq, 32'h0, "cleared irq");
        // Loopback run, clean and with line 2 broken
        for (k = 0; k < 2; k++) begin
            break_line <= k[0];
            apb(1'b1, NPTC_LBCMD_OFF, 32'h1);
            for (i = 0; i < 40; i++) begin
                apb(1'b0, NPTC_LBSTAT_OFF, 32'h0);
                if (q[NPTC_LB_BUSY_BIT] === 1'b0) break;
            end
            if (i == 40) begin
                n_mismatch++;
                end_sim();
            end
            chk(q, k ? 32'h490 : 32'h0d0, "loopback result");
            rd(NPTC_ISTAT_OFF, k ? 32'h6 : 32'h2, "loopback event");
            apb(1'b1, NPTC_ISTAT_OFF, 32'h7);
        end
        end_sim();
    end
endmodule
